// ### rtl/intc_pkg.sv
// constants, types and state layout of the pin and peripheral interrupt controller
// assumes one system clock and an apb master with 32-bit data
`default_nettype none

package intc_pkg;

  // source counts
  localparam int N_WAKE   = 8;
  localparam int N_EXT    = 2;
  localparam int N_PERIPH = 7;
  localparam int N_CH     = 11;

  // register byte offsets
  localparam logic [11:0] OFF_ENABLE_ONE  = 12'h000;
  localparam logic [11:0] OFF_ENABLE_TWO  = 12'h004;
  localparam logic [11:0] OFF_REQUEST_ONE = 12'h008;
  localparam logic [11:0] OFF_REQUEST_TWO = 12'h00c;
  localparam logic [11:0] OFF_WAKE_FLAG   = 12'h010;
  localparam logic [11:0] OFF_EDGE_SEL    = 12'h014;
  localparam logic [11:0] OFF_EVT_EDGE    = 12'h018;
  localparam logic [11:0] OFF_WAKE_EDGE   = 12'h01c;
  localparam logic [11:0] OFF_PIN_FUNC    = 12'h020;
  localparam logic [11:0] OFF_COND_CODE   = 12'h024;
  localparam logic [11:0] OFF_STATUS      = 12'h028;

  // field positions in enable_reg_one and request_reg_one, the condition code mask bit and the pin_func ext bits
  localparam int BIT_EXT_ZERO  = 0;
  localparam int BIT_EXT_ONE   = 1;
  localparam int BIT_EVT       = 2;
  localparam int BIT_WAKE_EN   = 5;
  localparam int BIT_PERIPH_LO = 6;
  localparam int BIT_MASK      = 7;
  localparam int BIT_PF_EXT    = 8;
  localparam logic [7:0] ONE_MASK = 8'he7;
  localparam logic [7:0] TWO_MASK = 8'h1f;

  // reset values
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic       MASK_RST = 1'b1;

  // evt edge field codes
  localparam logic [1:0] EVT_FALL = 2'h0;
  localparam logic [1:0] EVT_RISE = 2'h1;

  // exception entry phase lengths in states
  localparam logic [3:0] STACK_STATES    = 4'h4;
  localparam logic [3:0] VFETCH_STATES   = 4'h2;
  localparam logic [3:0] IFETCH_STATES   = 4'h4;
  localparam logic [3:0] INTERNAL_STATES = 4'h4;

  // channel vectors: ext0, ext1, evt, wakeup, periph0..6
  localparam logic [4:0] CH_VEC [N_CH] = '{5'h04, 5'h05, 5'h06, 5'h09, 5'h14, 5'h13,
                                           5'h12, 5'h0f, 5'h0e, 5'h0c, 5'h0b};
  // channel indices from highest to lowest priority
  localparam int CH_PRIO [N_CH] = '{0, 1, 2, 3, 10, 9, 8, 7, 6, 5, 4};
  localparam int VEC_ADDR_SHIFT = 1;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT     = 3'b001,
    ST_STACK    = 3'b010,
    ST_VFETCH   = 3'b011,
    ST_IFETCH   = 3'b100,
    ST_INTERNAL = 3'b101
  } entry_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic        exc_req;
    logic        stack_push;
    logic        vector_fetch;
    logic        instr_fetch;
    logic        internal;
    logic        handler_start;
    logic [4:0]  vector_num;
    logic [15:0] vector_addr;
  } cpu_exc_s;

  typedef struct packed {
    logic [7:0]  wake_s1;
    logic [7:0]  wake_s2;
    logic [7:0]  wake_d;
    logic [1:0]  ext_s1;
    logic [1:0]  ext_s2;
    logic [1:0]  ext_d;
    logic        evt_s1;
    logic        evt_s2;
    logic        evt_d;
    logic [7:0]  en_one;
    logic [7:0]  en_two;
    logic [7:0]  req_one;
    logic [7:0]  req_two;
    logic [7:0]  wake_flag;
    logic [1:0]  edge_sel;
    logic [1:0]  evt_edge;
    logic [7:0]  wake_edge;
    logic [9:0]  pin_func;
    logic        mask;
    entry_e      fsm;
    logic [3:0]  cnt;
    logic [4:0]  vec;
    logic [31:0] prdata;
  } state_s;

endpackage

`default_nettype wire

// ### rtl/pin_and_peripheral_intc.sv
// pin and peripheral interrupt controller with exception entry sequencer
// assumes apb master on mclk_i, asynchronous pins, cpu reports instruction end
// Operation
// RULE1: enabled wakeup pin edge sets its own wakeup flag bit
// RULE2: wakeup enable low ignores all eight wakeup requests
// RULE3: all wakeup pins share vector 9
// RULE4: each external request pin senses rising or falling edge per select bit
// RULE5: external pin edge sets flag in request_reg_one; own enable disables it
// RULE6: ext zero vector 4, ext one vector 5, zero wins
// RULE7: event pin senses rising, falling or both edges by two-bit field
// RULE8: event flag set only with its enable one and chosen edge seen
// RULE9: event request uses vector 6 and sets mask when handling begins
// RULE10: seven peripheral requests set flags in request regs, each with enable
// RULE11: peripheral vectors are 20, 19, 18, 15, 14, 12 and 11
// RULE12: global mask bit blocks acceptance of all requests
// RULE13: request forwarded only while its enable is one, then flag set
// RULE14: highest-priority pending flag selected, others stay pending
// RULE15: selected request accepted when mask zero, held when mask one
// RULE16: finish current instruction, then push counter and condition codes
// RULE17: exception entry sets the global mask bit
// RULE18: vector address formed, handler address read, execution starts there
// RULE19: software clears enables or flags only while masked
// RULE20: clear conflicting with request: exception follows the clearing access
// RULE21: wait 1 to 13 states for instruction end, 15 to 27 total
// RULE22: entry is 4 stack, 2 vector, 4 fetch, 4 internal states
// RULE23: flags stay set after acceptance; write zero clears, one does nothing
// RULE24: wakeup edge select 0 falling (reset), 1 rising
// RULE25: priority follows a fixed design-time table
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

module pin_and_peripheral_intc (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  // register bus
  input  wire intc_pkg::apb_req_s apb_i,
  output intc_pkg::apb_rsp_s     apb_o,
  // pins
  input  wire logic [7:0]        wakeup_pins_i,
  input  wire logic [1:0]        ext_request_i,
  input  wire logic              event_counter_pin_i,
  // peripheral requests
  input  wire logic [6:0]        periph_req_i,
  // cpu core
  input  wire logic              instr_done_i,
  output intc_pkg::cpu_exc_s     cpu_o,
  output logic                   mask_o
);

  intc_pkg::state_s r_r;
  intc_pkg::state_s r_nxt;

  logic [7:0]  wake_hit;
  logic [1:0]  ext_hit;
  logic        evt_hit;
  logic [6:0]  periph_hit;
  logic [6:0]  periph_en;
  logic [6:0]  periph_flag;
  logic [10:0] pend;
  logic        any_pend;
  logic [3:0]  sel_ch;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        wr;
  logic [7:0]  wd;
  logic [31:0] rd;

  // bus decode
  always_comb begin
    setup  = apb_i.psel & ~apb_i.penable;
    access = apb_i.psel & apb_i.penable;
    case (apb_i.paddr)
      intc_pkg::OFF_ENABLE_ONE,
      intc_pkg::OFF_ENABLE_TWO,
      intc_pkg::OFF_REQUEST_ONE,
      intc_pkg::OFF_REQUEST_TWO,
      intc_pkg::OFF_WAKE_FLAG,
      intc_pkg::OFF_EDGE_SEL,
      intc_pkg::OFF_EVT_EDGE,
      intc_pkg::OFF_WAKE_EDGE,
      intc_pkg::OFF_PIN_FUNC,
      intc_pkg::OFF_COND_CODE,
      intc_pkg::OFF_STATUS: mapped = 1'b1;
      default:              mapped = 1'b0;
    endcase
    wr = access & apb_i.pwrite & apb_i.pstrb[0] & mapped;
    wd = apb_i.pwdata[7:0];
  end

  // read mux
  always_comb begin
    rd = 32'h0;
    case (apb_i.paddr)
      intc_pkg::OFF_ENABLE_ONE:  rd[7:0] = r_r.en_one;
      intc_pkg::OFF_ENABLE_TWO:  rd[7:0] = r_r.en_two;
      intc_pkg::OFF_REQUEST_ONE: rd[7:0] = r_r.req_one;
      intc_pkg::OFF_REQUEST_TWO: rd[7:0] = r_r.req_two;
      intc_pkg::OFF_WAKE_FLAG:   rd[7:0] = r_r.wake_flag;
      intc_pkg::OFF_EDGE_SEL:    rd[1:0] = r_r.edge_sel;
      intc_pkg::OFF_EVT_EDGE:    rd[1:0] = r_r.evt_edge;
      intc_pkg::OFF_WAKE_EDGE:   rd[7:0] = r_r.wake_edge;
      intc_pkg::OFF_PIN_FUNC:    rd[9:0] = r_r.pin_func;
      intc_pkg::OFF_COND_CODE:   rd[intc_pkg::BIT_MASK] = r_r.mask;
      intc_pkg::OFF_STATUS:      rd[15:0] = {any_pend, 4'h0, r_r.fsm, 3'h0, r_r.vec};
      default:                   rd = 32'h0;
    endcase
  end

  // edge detection and source gating
  always_comb begin
    for (int i = 0; i < intc_pkg::N_WAKE; i++) begin
      wake_hit[i] = r_r.pin_func[i] & r_r.en_one[intc_pkg::BIT_WAKE_EN] &       // [RULE1] [RULE2]
                    (r_r.wake_edge[i] ? (r_r.wake_s2[i] & ~r_r.wake_d[i])        // [RULE24]
                                      : (~r_r.wake_s2[i] & r_r.wake_d[i]));
    end
    for (int i = 0; i < intc_pkg::N_EXT; i++) begin
      ext_hit[i] = r_r.pin_func[intc_pkg::BIT_PF_EXT + i] &                      // [RULE5]
                   r_r.en_one[intc_pkg::BIT_EXT_ZERO + i] &                      // [RULE13]
                   (r_r.edge_sel[i] ? (r_r.ext_s2[i] & ~r_r.ext_d[i])           // [RULE4]
                                    : (~r_r.ext_s2[i] & r_r.ext_d[i]));
    end
    case (r_r.evt_edge)                                                          // [RULE7]
      intc_pkg::EVT_FALL: evt_hit = ~r_r.evt_s2 & r_r.evt_d;
      intc_pkg::EVT_RISE: evt_hit = r_r.evt_s2 & ~r_r.evt_d;
      default:            evt_hit = r_r.evt_s2 ^ r_r.evt_d;
    endcase
    evt_hit     = evt_hit & r_r.en_one[intc_pkg::BIT_EVT];                       // [RULE8]
    periph_en   = {r_r.en_two[4:0], r_r.en_one[7:6]};
    periph_flag = {r_r.req_two[4:0], r_r.req_one[7:6]};
    periph_hit  = periph_req_i & periph_en;                                      // [RULE10] [RULE13]
  end

  // pending channels and priority pick
  always_comb begin
    pend[0] = r_r.req_one[intc_pkg::BIT_EXT_ZERO] & r_r.en_one[intc_pkg::BIT_EXT_ZERO];
    pend[1] = r_r.req_one[intc_pkg::BIT_EXT_ONE] & r_r.en_one[intc_pkg::BIT_EXT_ONE];
    pend[2] = r_r.req_one[intc_pkg::BIT_EVT] & r_r.en_one[intc_pkg::BIT_EVT];
    pend[3] = (|r_r.wake_flag) & r_r.en_one[intc_pkg::BIT_WAKE_EN];             // [RULE2] [RULE3]
    pend[10:4] = periph_flag & periph_en;
    any_pend = |pend;
    sel_ch   = 4'h0;
    for (int k = intc_pkg::N_CH - 1; k >= 0; k--) begin                         // [RULE14] [RULE25]
      if (pend[intc_pkg::CH_PRIO[k]]) begin
        sel_ch = 4'(intc_pkg::CH_PRIO[k]);                                       // [RULE6]
      end
    end
  end

  // next state
  always_comb begin
    r_nxt = r_r;
    // pin synchronisers and edge history
    r_nxt.wake_s1 = wakeup_pins_i;
    r_nxt.wake_s2 = r_r.wake_s1;
    r_nxt.wake_d  = r_r.wake_s2;
    r_nxt.ext_s1  = ext_request_i;
    r_nxt.ext_s2  = r_r.ext_s1;
    r_nxt.ext_d   = r_r.ext_s2;
    r_nxt.evt_s1  = event_counter_pin_i;
    r_nxt.evt_s2  = r_r.evt_s1;
    r_nxt.evt_d   = r_r.evt_s2;

    // read data captured in setup phase
    if (setup) begin
      r_nxt.prdata = rd;
    end

    // configuration writes
    if (wr && apb_i.paddr == intc_pkg::OFF_ENABLE_ONE) begin
      r_nxt.en_one = wd & intc_pkg::ONE_MASK;
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_ENABLE_TWO) begin
      r_nxt.en_two = wd & intc_pkg::TWO_MASK;
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_EDGE_SEL) begin
      r_nxt.edge_sel = wd[1:0];
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_EVT_EDGE) begin
      r_nxt.evt_edge = wd[1:0];
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_WAKE_EDGE) begin
      r_nxt.wake_edge = wd;
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_PIN_FUNC) begin
      r_nxt.pin_func = {apb_i.pwdata[9:8] & {2{apb_i.pstrb[1]}}, wd};
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_COND_CODE) begin
      r_nxt.mask = wd[intc_pkg::BIT_MASK];
    end

    // flags: write zero clears, one keeps, a new set wins
    if (wr && apb_i.paddr == intc_pkg::OFF_REQUEST_ONE) begin
      r_nxt.req_one = r_r.req_one & wd;                                          // [RULE23]
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_REQUEST_TWO) begin
      r_nxt.req_two = r_r.req_two & wd;                                          // [RULE23]
    end
    if (wr && apb_i.paddr == intc_pkg::OFF_WAKE_FLAG) begin
      r_nxt.wake_flag = r_r.wake_flag & wd;                                      // [RULE23]
    end
    r_nxt.req_one = (r_nxt.req_one | {periph_hit[1:0], 3'h0, evt_hit, ext_hit})   // [RULE5] [RULE8]
                    & intc_pkg::ONE_MASK;
    r_nxt.req_two = (r_nxt.req_two | {3'h0, periph_hit[6:2]}) & intc_pkg::TWO_MASK; // [RULE10]
    r_nxt.wake_flag = r_nxt.wake_flag | wake_hit;                                // [RULE1]

    // exception entry sequencer
    case (r_r.fsm)
      intc_pkg::ST_IDLE: begin
        // a bus access in flight finishes before acceptance
        if (any_pend && !r_r.mask && !apb_i.psel) begin                          // [RULE12] [RULE15] [RULE20]
          r_nxt.vec = intc_pkg::CH_VEC[sel_ch];                                  // [RULE3] [RULE9] [RULE11]
          r_nxt.fsm = intc_pkg::ST_WAIT;
        end
      end
      intc_pkg::ST_WAIT: begin
        if (instr_done_i) begin                                                  // [RULE16] [RULE21]
          r_nxt.fsm  = intc_pkg::ST_STACK;
          r_nxt.cnt  = intc_pkg::STACK_STATES - 4'h1;
        end
      end
      intc_pkg::ST_STACK: begin
        r_nxt.mask = 1'b1;                                                       // [RULE9] [RULE17]
        r_nxt.cnt  = r_r.cnt - 4'h1;
        if (r_r.cnt == 4'h0) begin                                               // [RULE22]
          r_nxt.fsm = intc_pkg::ST_VFETCH;
          r_nxt.cnt = intc_pkg::VFETCH_STATES - 4'h1;
        end
      end
      intc_pkg::ST_VFETCH: begin
        r_nxt.cnt = r_r.cnt - 4'h1;
        if (r_r.cnt == 4'h0) begin                                               // [RULE22]
          r_nxt.fsm = intc_pkg::ST_IFETCH;
          r_nxt.cnt = intc_pkg::IFETCH_STATES - 4'h1;
        end
      end
      intc_pkg::ST_IFETCH: begin
        r_nxt.cnt = r_r.cnt - 4'h1;
        if (r_r.cnt == 4'h0) begin                                               // [RULE22]
          r_nxt.fsm = intc_pkg::ST_INTERNAL;
          r_nxt.cnt = intc_pkg::INTERNAL_STATES - 4'h1;
        end
      end
      intc_pkg::ST_INTERNAL: begin
        r_nxt.cnt = r_r.cnt - 4'h1;
        if (r_r.cnt == 4'h0) begin                                               // [RULE22]
          r_nxt.fsm = intc_pkg::ST_IDLE;
          r_nxt.cnt = 4'h0;
        end
      end
      default: begin
        r_nxt.fsm = intc_pkg::ST_IDLE;
        r_nxt.cnt = 4'h0;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_r           <= '0;
      r_r.en_one    <= intc_pkg::REG_RST;
      r_r.wake_edge <= intc_pkg::REG_RST;                                        // [RULE24]
      r_r.mask      <= intc_pkg::MASK_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // bus answer: zero wait states, error on unmapped address
  always_comb begin
    apb_o.pready  = access;
    apb_o.prdata  = r_r.prdata;
    apb_o.pslverr = access & ~mapped;
  end

  // cpu side strobes
  always_comb begin
    cpu_o.exc_req       = (r_r.fsm == intc_pkg::ST_WAIT);                        // [RULE16]
    cpu_o.stack_push    = (r_r.fsm == intc_pkg::ST_STACK);                       // [RULE16]
    cpu_o.vector_fetch  = (r_r.fsm == intc_pkg::ST_VFETCH);                      // [RULE18]
    cpu_o.instr_fetch   = (r_r.fsm == intc_pkg::ST_IFETCH);                      // [RULE18]
    cpu_o.internal      = (r_r.fsm == intc_pkg::ST_INTERNAL);
    cpu_o.handler_start = (r_r.fsm == intc_pkg::ST_INTERNAL) && (r_r.cnt == 4'h0);
    cpu_o.vector_num    = r_r.vec;
    cpu_o.vector_addr   = 16'(r_r.vec) << intc_pkg::VEC_ADDR_SHIFT;              // [RULE18]
    mask_o              = r_r.mask;
  end

endmodule // pin_and_peripheral_intc

`default_nettype wire

// ### tb/intc_checker.sv
// assertions on the ports of the pin and peripheral interrupt controller
// assumes it is bound to the controller with a single clock domain
`timescale 1ns/1ns
`default_nettype none

module intc_checker (
  // clock and reset
  input wire logic               mclk_i,
  input wire logic               reset_n_i,
  // bus and cpu side
  input wire intc_pkg::apb_req_s apb_i,
  input wire logic               instr_done_i,
  input wire intc_pkg::cpu_exc_s cpu_o,
  input wire logic               mask_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  property p_entry_seq;
    cpu_o.exc_req && instr_done_i |=> cpu_o.stack_push [*4] ##1 cpu_o.vector_fetch [*2]
      ##1 cpu_o.instr_fetch [*4] ##1 cpu_o.internal [*4] ##1 !cpu_o.internal;
  endproperty
  a_entry_seq: assert property (p_entry_seq) else $error("entry phases wrong");

  property p_mask_set;
    $rose(cpu_o.stack_push) |=> mask_o;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set on entry");

  property p_accept_unmasked;
    $rose(cpu_o.exc_req) |-> !$past(mask_o);
  endproperty
  a_accept_unmasked: assert property (p_accept_unmasked) else $error("accepted while masked");

  property p_accept_idle_bus;
    $rose(cpu_o.exc_req) |-> !$past(apb_i.psel);
  endproperty
  a_accept_idle_bus: assert property (p_accept_idle_bus) else $error("accepted during access");

  property p_wait_hold;
    cpu_o.exc_req && !instr_done_i |=> cpu_o.exc_req;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("request dropped early");

  property p_vec_legal;
    cpu_o.exc_req |-> cpu_o.vector_num inside {5'h04, 5'h05, 5'h06, 5'h09, 5'h14, 5'h13,
      5'h12, 5'h0f, 5'h0e, 5'h0c, 5'h0b};
  endproperty
  a_vec_legal: assert property (p_vec_legal) else $error("unknown vector");

  property p_vec_addr;
    cpu_o.vector_fetch |-> cpu_o.vector_addr == {10'h000, cpu_o.vector_num, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

  property p_mask_hold;
    $fell(mask_o) |-> $past(apb_i.psel && apb_i.penable && apb_i.pwrite
      && apb_i.paddr == intc_pkg::OFF_COND_CODE);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask cleared by itself");

  property p_start_end;
    cpu_o.handler_start |-> cpu_o.internal ##1 (!cpu_o.handler_start && !cpu_o.internal);
  endproperty
  a_start_end: assert property (p_start_end) else $error("handler start wrong");
endmodule // intc_checker

`default_nettype wire

// ### tb/cpu_model.sv
// behavioural cpu core that ends its current instruction after a set delay
// assumes the bench picks the delay and the controller raises exc_req
`timescale 1ns/1ns
`default_nettype none

module cpu_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // controller side
  input  wire logic       exc_req_i,
  input  wire logic [3:0] lat_i,
  output logic            instr_done_o
);
  logic [3:0] cnt_r;

  // instruction ends 1 to 13 states into the request
  assign instr_done_o = exc_req_i && (cnt_r == lat_i);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= exc_req_i ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule // cpu_model

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the pin and peripheral interrupt controller
// assumes the package, controller, checker and cpu model compiled before it
`timescale 1ns/1ns
`default_nettype none

module tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_s;
  logic               mclk_i;
  logic               reset_n_i;
  intc_pkg::apb_req_s apb_i;
  intc_pkg::apb_rsp_s apb_o;
  logic [7:0]         wakeup_pins_i;
  logic [1:0]         ext_request_i;
  logic               event_counter_pin_i;
  logic [6:0]         periph_req_i;
  logic               instr_done_i;
  intc_pkg::cpu_exc_s cpu_o;
  logic               mask_o;
  logic [3:0]         lat;
  logic [31:0]        rdat;
  logic [31:0]        rtmp;
  logic               rerr;
  int                 fail_count;
  int                 check_count;
  row_s               rows [7];
  logic [4:0]         pvec [7] = '{5'h14, 5'h13, 5'h12, 5'h0f, 5'h0e, 5'h0c, 5'h0b};

  pin_and_peripheral_intc dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .apb_i(apb_i),
    .apb_o(apb_o), .wakeup_pins_i(wakeup_pins_i), .ext_request_i(ext_request_i),
    .event_counter_pin_i(event_counter_pin_i), .periph_req_i(periph_req_i),
    .instr_done_i(instr_done_i), .cpu_o(cpu_o), .mask_o(mask_o));
  cpu_model cpu (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .exc_req_i(cpu_o.exc_req),
    .lat_i(lat), .instr_done_o(instr_done_i));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hf};
    @(posedge mclk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
    rdat = apb_o.prdata;
    rerr = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task wait_on(input bit start);
    int n;
    n = 0;
    while ((start ? cpu_o.handler_start : cpu_o.exc_req) !== 1'b1) begin
      @(posedge mclk_i);
      n++;
      if (n > 60) begin
        fail_count++;
        wrap_up();
      end
    end
  endtask

  // masked wait, then unmask and follow one exception entry
  task take(input logic [4:0] v);
    repeat (6) @(posedge mclk_i);
    chk(32'(cpu_o.exc_req), 32'h0);
    lat <= (lat == 4'hc) ? 4'h0 : lat + 4'h3;
    bus(1'b1, intc_pkg::OFF_COND_CODE, 32'h0);
    wait_on(1'b0);
    chk(32'(cpu_o.vector_num), 32'(v));
    wait_on(1'b1);
    chk(32'(mask_o), 32'h1);
  endtask

  // clear every flag while masked
  task clr;
    bus(1'b1, intc_pkg::OFF_REQUEST_ONE, 32'h0);
    bus(1'b1, intc_pkg::OFF_REQUEST_TWO, 32'h0);
    bus(1'b1, intc_pkg::OFF_WAKE_FLAG, 32'h0);
  endtask

  task pulse(input int i);
    @(posedge mclk_i);
    periph_req_i <= 7'h01 << i;
    @(posedge mclk_i);
    periph_req_i <= 7'h00;
  endtask

  initial begin
    reset_n_i = 1'b0;
    apb_i = '0;
    wakeup_pins_i = 8'h00;
    ext_request_i = 2'h0;
    event_counter_pin_i = 1'b0;
    periph_req_i = 7'h00;
    lat = 4'h0;
    fail_count = 0;
    check_count = 0;
    rows = '{'{intc_pkg::OFF_ENABLE_ONE, 32'h0ff, 32'h0e7, 1'b0},
      '{intc_pkg::OFF_ENABLE_TWO, 32'h0ff, 32'h01f, 1'b0},
      '{intc_pkg::OFF_EDGE_SEL, 32'h0ff, 32'h003, 1'b0},
      '{intc_pkg::OFF_EVT_EDGE, 32'h002, 32'h002, 1'b0},
      '{intc_pkg::OFF_WAKE_EDGE, 32'h0a5, 32'h0a5, 1'b0},
      '{intc_pkg::OFF_PIN_FUNC, 32'h3ff, 32'h3ff, 1'b0}, '{12'h030, 32'h0ff, 32'h000, 1'b1}};
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      chk(32'(rerr), 32'(rows[i].err));
      bus(1'b0, rows[i].a, 32'h0);
      chk(rdat, rows[i].e);
    end
    clr();
    $display("test table done");
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      take(pvec[i]);
      bus(1'b0, intc_pkg::OFF_REQUEST_ONE, 32'h0);
      rtmp = rdat;
      bus(1'b0, intc_pkg::OFF_REQUEST_TWO, 32'h0);
      chk({16'h0, rdat[7:0], rtmp[7:0]}, i < 2 ? 32'h40 << i : 32'h100 << (i - 2));
      clr();
    end
    bus(1'b1, intc_pkg::OFF_ENABLE_TWO, 32'h0);
    pulse(6);
    bus(1'b0, intc_pkg::OFF_REQUEST_TWO, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, intc_pkg::OFF_ENABLE_TWO, 32'h1f);
    $display("test peripherals done");
    ext_request_i <= 2'h3;
    pulse(6);
    take(5'h04);
    bus(1'b1, intc_pkg::OFF_REQUEST_ONE, 32'hfe);
    take(5'h05);
    bus(1'b1, intc_pkg::OFF_REQUEST_ONE, 32'hfc);
    take(5'h0b);
    bus(1'b1, intc_pkg::OFF_EDGE_SEL, 32'h0);
    @(posedge mclk_i);
    ext_request_i <= 2'h0;
    take(5'h04);
    clr();
    $display("test priority done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, intc_pkg::OFF_EVT_EDGE, (k < 2) ? 32'(1 - k) : 32'(k));
      @(posedge mclk_i);
      event_counter_pin_i <= ~event_counter_pin_i;
      take(5'h06);
      clr();
    end
    // rising edge while falling is chosen must not set the flag
    bus(1'b1, intc_pkg::OFF_EVT_EDGE, 32'h0);
    event_counter_pin_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    bus(1'b0, intc_pkg::OFF_REQUEST_ONE, 32'h0);
    chk(rdat, 32'h0);
    $display("test event pin done");
    @(posedge mclk_i);
    wakeup_pins_i <= 8'hff;
    take(5'h09);
    bus(1'b0, intc_pkg::OFF_WAKE_FLAG, 32'h0);
    chk(rdat, 32'ha5);
    clr();
    bus(1'b1, intc_pkg::OFF_ENABLE_ONE, 32'hc7);
    wakeup_pins_i <= 8'h00;
    repeat (6) @(posedge mclk_i);
    bus(1'b1, intc_pkg::OFF_COND_CODE, 32'h0);
    repeat (6) @(posedge mclk_i);
    chk(32'(cpu_o.exc_req), 32'h0);
    bus(1'b1, intc_pkg::OFF_COND_CODE, 32'h80);
    clr();
    $display("test wakeup done");
    // request arriving while a bus access is in flight, unmasked
    bus(1'b1, intc_pkg::OFF_COND_CODE, 32'h0);
    periph_req_i <= 7'h01;
    bus(1'b0, intc_pkg::OFF_STATUS, 32'h0);
    periph_req_i <= 7'h00;
    chk(rdat, 32'h8009);
    wait_on(1'b0);
    chk(32'(cpu_o.vector_num), 32'h14);
    wait_on(1'b1);
    clr();
    $display("test bus conflict done");
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    chk(32'(mask_o), 32'h1);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk(rdat, 32'h0);
    end
    bus(1'b0, intc_pkg::OFF_COND_CODE, 32'h0);
    chk(rdat, 32'h80);
    $display("test reset done");
    wrap_up();
  end
endmodule // tb

bind pin_and_peripheral_intc intc_checker u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .apb_i(apb_i), .instr_done_i(instr_done_i), .cpu_o(cpu_o), .mask_o(mask_o));

`default_nettype wire
